// *** common/spi_master_port_pkg.sv ***
// Constants shared by the serial master port and its buffer.
package spi_master_port_pkg;
  // Special function register addresses.
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hd2;
  localparam logic [7:0] ADDR_STATUS_FLAGS  = 8'hd3;
  localparam logic [7:0] ADDR_TX_HOLDING    = 8'hd4;
  localparam logic [7:0] ADDR_RX_HOLDING    = 8'hd5;
  localparam logic [7:0] ADDR_CONTROL_MAIN  = 8'hd6;
  localparam logic [7:0] ADDR_IRQ_ENABLES   = 8'hd7;

  // Reset values.
  localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h04;
  localparam logic [7:0] RST_CONTROL_MAIN  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES   = 8'h00;
  localparam logic [7:0] RST_STATUS_FLAGS  = 8'h02;

  // Control register fields.
  localparam int BIT_TX_PATH_ON     = 6;
  localparam int BIT_RX_PATH_ON     = 5;
  localparam int BIT_IFACE_ON       = 4;
  localparam int BIT_AUTO_SELECT    = 3;
  localparam int BIT_LSB_ORDER_SEL  = 2;
  localparam int BIT_CLOCK_IDLE_HIGH = 1;
  localparam logic [7:0] CONTROL_MAIN_MASK = 8'h7e;
  localparam logic [7:0] IRQ_ENABLES_MASK  = 8'h0f;
  localparam logic [7:0] CLOCK_DIVIDER_MASK = 8'hfc;

  // Status register fields.
  localparam int BIT_BUSY         = 4;
  localparam int BIT_TX_END_FLAG  = 3;
  localparam int BIT_OVERRUN_FLAG = 2;
  localparam int BIT_TX_EMPTY_FLAG = 1;
  localparam int BIT_RX_FULL_FLAG = 0;

  localparam int          BYTE_BITS = 8;
  localparam logic [3:0]  LAST_BIT  = 4'h7;
  localparam logic [7:0]  MIN_HALF_PERIOD = 8'h01;
  localparam int          FIFO_DEPTH_DEFAULT = 4;
endpackage

// *** core/spi_master_port.sv ***
// Master-only serial port with special function registers and a transmit FIFO.

// Small first-in first-out buffer; a write into a full buffer is refused.
module spi_master_port_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } fifo_s;
  fifo_s st_q, st_d;
  logic push, pop;

  // Pointer advance with wrap, shared by both ends.
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
    bump = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
  endfunction

  // Full and empty come from one count, so the two can never disagree
  // about a word that is being written and read in the same cycle.
  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = bump(st_q.wr);
    end
    if (pop) begin
      st_d.rd = bump(st_q.rd);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

module spi_master_port #(
  parameter int TX_FIFO_DEPTH = spi_master_port_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset.
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  // Special function register access.
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // Interrupt request to the MCU.
  output logic            IRQ,
  // Serial pins.
  output logic            SERIAL_CLOCK_OUT,
  output logic            SERIAL_DATA_OUT,
  input  wire logic       SERIAL_DATA_IN,
  output logic            SLAVE_SELECT_OUT_N,
  // Transmit FIFO can take another byte.
  output logic            TX_READY
);
  import spi_master_port_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10,
    ST_GAP   = 2'b11
  } phase_e;

  typedef struct packed {
    phase_e     phase;
    logic [7:0] clock_divider;
    logic [7:0] control_main;
    logic [7:0] irq_enables;
    logic [3:0] flags;
    logic [7:0] rx_holding;
    logic       rx_unread;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [3:0] bit_cnt;
    logic [7:0] div_cnt;
    logic       sclk;
    logic       mosi;
    logic       ssel_n;
    logic [2:0] din_sync;
    logic       din;
    logic [7:0] rdata;
  } state_s;

  state_s st_q, st_d;
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic       fifo_push;
  logic       fifo_ready;
  logic       running;
  logic       half_tick;
  logic       lsb_first;
  logic       idle_high;
  logic       byte_done;
  logic       rd_status;
  logic       rd_rx;

  function automatic logic [7:0] next_out(input logic [7:0] sr, input logic lsb);
    next_out = lsb ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
  endfunction

  function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
    out_bit = lsb ? sr[0] : sr[7];
  endfunction

  // Received bits enter at the end opposite to the one that leaves first.
  function automatic logic [7:0] rx_next(input logic [7:0] sr, input logic lsb,
                                         input logic bit_in);
    rx_next = lsb ? {bit_in, sr[7:1]} : {sr[6:0], bit_in};
  endfunction

  // Half a serial clock period in reference cycles. A divider of zero would wrap the compare
  // to 255 and give the longest half period, so it is held to the shortest half period instead.
  function automatic logic [7:0] half_len(input logic [7:0] divider);
    if (divider[7:1] == 7'h00) begin
      half_len = MIN_HALF_PERIOD;
    end else begin
      half_len = {1'b0, divider[7:1]};
    end
  endfunction

  // Writes to the transmit holding address enter the FIFO; a full FIFO drops them.
  assign fifo_push = SFR_WR && (SFR_ADDR == ADDR_TX_HOLDING);
  assign TX_READY  = fifo_ready;

  // A few bytes of depth let software queue a burst while one byte still shifts.
  spi_master_port_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (SFR_WDATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // The interface enable gates the transmitter enable, which gates taking and shifting bytes.
  assign running   = st_q.control_main[BIT_IFACE_ON] && st_q.control_main[BIT_TX_PATH_ON];
  assign lsb_first = st_q.control_main[BIT_LSB_ORDER_SEL];
  assign idle_high = st_q.control_main[BIT_CLOCK_IDLE_HIGH];
  // The divider byte is the sum of weights; a half period is half of it.
  assign half_tick = (st_q.div_cnt >= half_len(st_q.clock_divider) - 8'h01);
  // A byte is only taken between frames, so a new byte never cuts one in flight.
  assign fifo_pop  = (st_q.phase == ST_IDLE || st_q.phase == ST_GAP) && running && fifo_valid;
  assign byte_done = (st_q.phase == ST_TRAIL) && half_tick && (st_q.bit_cnt == LAST_BIT);
  // Reads with side effects.
  assign rd_status = SFR_RD && (SFR_ADDR == ADDR_STATUS_FLAGS);
  assign rd_rx     = SFR_RD && (SFR_ADDR == ADDR_RX_HOLDING);

  always_comb begin
    st_d = st_q;
    // The pin is asynchronous; a level counts only once the last two stages agree,
    // which also keeps a one-cycle glitch out of the receive shifter.
    st_d.din_sync = {st_q.din_sync[1:0], SERIAL_DATA_IN};
    if (st_q.din_sync[2] == st_q.din_sync[1]) begin
      st_d.din = st_q.din_sync[2];
    end
    st_d.rdata = 8'h00;

    // Register reads.
    if (SFR_RD) begin
      unique case (SFR_ADDR)
        ADDR_CLOCK_DIVIDER: begin
          st_d.rdata = st_q.clock_divider;
        end
        ADDR_STATUS_FLAGS: begin
          st_d.rdata = {3'b000, st_q.phase != ST_IDLE, st_q.flags};
        end
        ADDR_RX_HOLDING: begin
          st_d.rdata = st_q.rx_holding;
        end
        ADDR_CONTROL_MAIN: begin
          st_d.rdata = st_q.control_main;
        end
        ADDR_IRQ_ENABLES: begin
          st_d.rdata = st_q.irq_enables;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
      // A flag that the shifter sets in this same cycle is applied further down and wins.
      if (rd_status) begin
        st_d.flags = 4'h0;
      end
      if (rd_rx) begin
        st_d.rx_unread = 1'b0;
      end
    end

    // Register writes. Reserved bits are dropped here so that they always read as zero.
    if (SFR_WR) begin
      unique case (SFR_ADDR)
        ADDR_CLOCK_DIVIDER: begin
          st_d.clock_divider = SFR_WDATA & CLOCK_DIVIDER_MASK;
        end
        ADDR_CONTROL_MAIN: begin
          st_d.control_main = SFR_WDATA & CONTROL_MAIN_MASK;
        end
        ADDR_IRQ_ENABLES: begin
          st_d.irq_enables = SFR_WDATA & IRQ_ENABLES_MASK;
        end
        default: begin
        end
      endcase
    end

    // Divider runs during a frame only.
    // Holding it at zero while idle gives the first half period of every byte full length.
    st_d.div_cnt = (half_tick || st_q.phase == ST_IDLE) ? 8'h00 : st_q.div_cnt + 8'h01;

    unique case (st_q.phase)
      ST_IDLE, ST_GAP: begin
        if (fifo_pop) begin
          // Load the shifter; the first bit appears with the first clock edge.
          st_d.tx_shift = fifo_data;
          st_d.bit_cnt  = 4'h0;
          // Automatic select is looked at only here, so clearing it lets a byte finish.
          st_d.ssel_n   = !st_q.control_main[BIT_AUTO_SELECT];
          st_d.flags[BIT_TX_EMPTY_FLAG] = 1'b1;
          st_d.phase    = ST_LEAD;
          st_d.div_cnt  = 8'h00;
        end else begin
          st_d.ssel_n = 1'b1;
          if (st_q.phase == ST_GAP) begin
            st_d.flags[BIT_TX_END_FLAG] = 1'b1;
          end
          st_d.phase = ST_IDLE;
        end
        st_d.sclk = idle_high;
      end
      ST_LEAD: begin
        // Dropping the interface or transmit enable abandons the byte at once; the slave sees a cut frame.
        if (!running) begin
          st_d.phase = ST_IDLE;
          st_d.sclk  = idle_high;
          st_d.ssel_n = 1'b1;
        end else if (half_tick) begin
          // Leading edge: rising for idle-low, falling for idle-high.
          st_d.sclk     = !idle_high;
          st_d.mosi     = out_bit(st_q.tx_shift, lsb_first);
          st_d.tx_shift = next_out(st_q.tx_shift, lsb_first);
          st_d.phase    = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (!running) begin
          st_d.phase = ST_IDLE;
          st_d.sclk  = idle_high;
          st_d.ssel_n = 1'b1;
        end else if (half_tick) begin
          // Trailing edge samples while transmit data is stable.
          st_d.sclk = idle_high;
          st_d.rx_shift = rx_next(st_q.rx_shift, lsb_first, st_q.din);
          st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          st_d.phase   = byte_done ? ST_GAP : ST_LEAD;
        end
      end
    endcase

    // Completed byte goes to the receive holding register.
    if (byte_done && st_q.control_main[BIT_RX_PATH_ON]) begin
      st_d.rx_holding = rx_next(st_q.rx_shift, lsb_first, st_q.din);
      st_d.flags[BIT_RX_FULL_FLAG] = 1'b1;
      if (st_q.rx_unread && !rd_rx) begin
        st_d.flags[BIT_OVERRUN_FLAG] = 1'b1;
      end
      st_d.rx_unread = 1'b1;
    end

    // Gap phase lasts one cycle; in either clock polarity the select lifts after bit eight when no byte waits.
    if (!st_q.control_main[BIT_IFACE_ON]) begin
      st_d.ssel_n = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= '{
        phase:         ST_IDLE,
        clock_divider: RST_CLOCK_DIVIDER,
        control_main:  RST_CONTROL_MAIN,
        irq_enables:   RST_IRQ_ENABLES,
        flags:         RST_STATUS_FLAGS[3:0],
        rx_holding:    8'h00,
        rx_unread:     1'b0,
        tx_shift:      8'h00,
        rx_shift:      8'h00,
        bit_cnt:       4'h0,
        div_cnt:       8'h00,
        sclk:          1'b0,
        mosi:          1'b0,
        ssel_n:        1'b1,
        din_sync:      3'b000,
        din:           1'b0,
        rdata:         8'h00
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Every serial pin comes straight from a flop, so no decode glitch reaches the slave.
  assign SFR_RDATA          = st_q.rdata;
  assign IRQ                = |(st_q.flags & st_q.irq_enables[3:0]);
  assign SERIAL_CLOCK_OUT   = st_q.sclk;
  assign SERIAL_DATA_OUT    = st_q.mosi;
  assign SLAVE_SELECT_OUT_N = st_q.ssel_n;
endmodule

// *** testbench/spi_master_port_properties.sv ***
// Pin-level properties of the serial master port.
module spi_master_port_checker (
  // Clock and reset.
  input wire logic       REF_CLK,
  input wire logic       RST,
  // Register access.
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Pins.
  input wire logic       IRQ,
  input wire logic       SERIAL_CLOCK_OUT,
  input wire logic       SERIAL_DATA_OUT,
  input wire logic       SLAVE_SELECT_OUT_N
);
  timeunit 1ns;
  timeprecision 1ps;
  import spi_master_port_pkg::*;
  logic [7:0] ctl_q, div_q, ien_q, cnt_q, half;
  logic       sck_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Shadow registers, because only the pins are visible from here.
  assign half = (div_q[7:1] == 7'h00) ? 8'h01 : {1'b0, div_q[7:1]};
  always_ff @(posedge REF_CLK) begin
    sck_q <= SERIAL_CLOCK_OUT;
    cnt_q <= (RST || SERIAL_CLOCK_OUT != sck_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
    if (RST) begin
      ctl_q <= RST_CONTROL_MAIN;
      div_q <= RST_CLOCK_DIVIDER;
      ien_q <= RST_IRQ_ENABLES;
    end else if (SFR_WR) begin
      if (SFR_ADDR == ADDR_CONTROL_MAIN) ctl_q <= SFR_WDATA;
      if (SFR_ADDR == ADDR_CLOCK_DIVIDER) div_q <= SFR_WDATA & CLOCK_DIVIDER_MASK;
      if (SFR_ADDR == ADDR_IRQ_ENABLES) ien_q <= SFR_WDATA;
    end
  end
  rdata_idle_a: assert property (!$past(SFR_RD) |-> SFR_RDATA == 8'h00)
    else $error("read data not zero");
  idle_level_a: assert property (!(ctl_q[6] && ctl_q[4]) && $stable(ctl_q)
    |=> SERIAL_CLOCK_OUT == $past(ctl_q[1])) else $error("clock not idle");
  hold_low_a: assert property ($fell(SERIAL_CLOCK_OUT) && !ctl_q[1]
    && !SLAVE_SELECT_OUT_N |-> $stable(SERIAL_DATA_OUT)) else $error("data moved at sample");
  hold_high_a: assert property ($rose(SERIAL_CLOCK_OUT) && ctl_q[1]
    && !SLAVE_SELECT_OUT_N |-> $stable(SERIAL_DATA_OUT)) else $error("data moved at sample");
  half_period_a: assert property ($changed(SERIAL_CLOCK_OUT) && !SLAVE_SELECT_OUT_N
    && SERIAL_CLOCK_OUT == ctl_q[1] |-> cnt_q == half - 8'h01) else $error("bad half period");
  select_frame_a: assert property ($changed(SERIAL_CLOCK_OUT) && ctl_q[3]
    && ctl_q == $past(ctl_q, 2) |-> !SLAVE_SELECT_OUT_N) else $error("clock outside select");
  irq_gate_a: assert property ((ien_q & IRQ_ENABLES_MASK) == 8'h00 |-> !IRQ)
    else $error("request while masked");
  div_read_a: assert property (SFR_RD && SFR_ADDR == ADDR_CLOCK_DIVIDER
    |=> SFR_RDATA == ($past(div_q) & CLOCK_DIVIDER_MASK)) else $error("bad divider read");
  cover property ($rose(SERIAL_CLOCK_OUT) && !ctl_q[1]);
  cover property ($fell(SERIAL_CLOCK_OUT) && ctl_q[1]);
  cover property ($rose(IRQ));
endmodule

bind spi_master_port spi_master_port_checker i_spi_master_port_checker (
  .REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .IRQ(IRQ), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SLAVE_SELECT_OUT_N(SLAVE_SELECT_OUT_N));

// *** testbench/spi_slave_model.sv ***
// Behavioural serial slave that answers the master port.
module spi_slave_model (
  // Serial pins.
  input wire logic       clk,
  input wire logic       sck,
  input wire logic       sdo,
  input wire logic       sel_n,
  output logic           sdi,
  // Mode and bytes.
  input wire logic       pol,
  input wire logic       lsb,
  input wire logic [7:0] tx_byte,
  output logic [7:0]     rx_byte,
  output logic           rx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sck_q = 1'b0;
  logic [2:0] n = 3'h0;
  initial sdi = 1'b0;
  initial rx_byte = 8'h00;
  initial rx_done = 1'b0;
  always @(posedge clk) begin
    rx_done <= 1'b0;
    sck_q <= sck;
    if (sel_n) begin
      // A released line floats, so show a moving level rather than the last bit.
      sdi <= ~sdi;
      n <= 3'h0;
    end else if (sck != sck_q && sck != pol) begin
      sdi <= lsb ? tx_byte[n] : tx_byte[3'h7 - n];
    end else if (sck != sck_q) begin
      rx_byte <= lsb ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
      n <= n + 3'h1;
      rx_done <= (n == 3'h7);
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the serial master port.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_master_port_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, pol = 1'b0;
  logic       lsb = 1'b0, irq, sck, sdo, sdi, sel_n, tx_rdy, sl_done;
  logic [7:0] addr = 8'h00, wdata = 8'h00, sl_tx = 8'h00, b, rdata, sl_rx;
  logic [7:0] exp_rd[$], exp_tx[$];
  int         err_count = 0, n_compared = 0, seed = 32'hc35b7ade;
  always #5 clk = ~clk;
  spi_master_port #(.TX_FIFO_DEPTH(4)) i_spi_master_port (.REF_CLK(clk), .RST(rst),
    .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .IRQ(irq), .SERIAL_CLOCK_OUT(sck), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_IN(sdi),
    .SLAVE_SELECT_OUT_N(sel_n), .TX_READY(tx_rdy));
  spi_slave_model i_spi_slave_model (.clk(clk), .sck(sck), .sdo(sdo), .sel_n(sel_n),
    .sdi(sdi), .pol(pol), .lsb(lsb), .tx_byte(sl_tx), .rx_byte(sl_rx), .rx_done(sl_done));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 6000 && (exp_tx.size() != 0 || sel_n !== 1'b1); i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(8'(exp_tx.size()), 8'h00);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Answers are checked one cycle after their request, in request order.
  always @(posedge clk) begin
    if (rd_d) chk(rdata, exp_rd.pop_front());
    if (sl_done) chk(sl_rx, exp_tx.pop_front());
    rd_d = rd;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rreg(ADDR_CLOCK_DIVIDER, RST_CLOCK_DIVIDER);
    rreg(ADDR_STATUS_FLAGS, RST_STATUS_FLAGS);
    rreg(ADDR_CONTROL_MAIN, RST_CONTROL_MAIN);
    rreg(ADDR_IRQ_ENABLES, RST_IRQ_ENABLES);
    rreg(8'hd8, 8'h00);
    wreg(ADDR_CLOCK_DIVIDER, 8'hff);
    rreg(ADDR_CLOCK_DIVIDER, 8'hfc);
    // A slow clock leaves room for the input synchroniser when receiving.
    wreg(ADDR_CLOCK_DIVIDER, 8'h24);
    for (int m = 0; m < 4; m++) begin
      pol = m[0];
      lsb = m[1];
      sl_tx = 8'($random(seed));
      b = 8'($random(seed));
      wreg(ADDR_CONTROL_MAIN, {5'h1f, lsb, pol, 1'b1});
      rreg(ADDR_CONTROL_MAIN, {5'h0f, lsb, pol, 1'b0});
      exp_tx.push_back(b);
      wreg(ADDR_TX_HOLDING, b);
      wait_done();
      rreg(ADDR_RX_HOLDING, sl_tx);
      rreg(ADDR_STATUS_FLAGS, 8'h0b);
      rreg(ADDR_STATUS_FLAGS, 8'h00);
    end
    wreg(ADDR_CLOCK_DIVIDER, RST_CLOCK_DIVIDER);
    wreg(ADDR_IRQ_ENABLES, 8'h08);
    wreg(ADDR_CONTROL_MAIN, 8'h58);
    pol = 1'b0;
    lsb = 1'b0;
    repeat (5) begin
      b = 8'($random(seed));
      exp_tx.push_back(b);
      wreg(ADDR_TX_HOLDING, b);
    end
    chk({7'h00, tx_rdy}, 8'h00);
    wreg(ADDR_TX_HOLDING, 8'ha5);
    wait_done();
    chk({7'h00, irq}, 8'h01);
    rreg(ADDR_RX_HOLDING, sl_tx);
    wreg(ADDR_IRQ_ENABLES, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rreg(ADDR_STATUS_FLAGS, 8'h0a);
    wreg(ADDR_CONTROL_MAIN, 8'h48);
    b = 8'($random(seed));
    exp_tx.push_back(b);
    wreg(ADDR_TX_HOLDING, b);
    wreg(ADDR_CONTROL_MAIN, 8'h18);
    repeat (40) @(negedge clk);
    chk({7'h00, sel_n}, 8'h01);
    rreg(ADDR_STATUS_FLAGS, 8'h00);
    wreg(ADDR_CONTROL_MAIN, 8'h58);
    for (int i = 0; i < 200 && sel_n !== 1'b0; i++) @(negedge clk);
    wreg(ADDR_CONTROL_MAIN, 8'h50);
    wait_done();
    chk({7'h00, sel_n}, 8'h01);
    repeat (2) @(negedge clk);
    print_verdict();
  end
endmodule
